/* File: core/sram_host_pkg.sv */
package sram_host_pkg;

  // ----------------------------------------------------------------
  // Clock and widths
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS     = 5;
  localparam int unsigned ADDR_W     = 19;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned LANES      = 2;
  localparam int unsigned NUM_GRADES = 3;

  // ----------------------------------------------------------------
  // Write timing per grade, fastest first, in ns
  // ----------------------------------------------------------------
  localparam int unsigned T_WC_NS     [NUM_GRADES] = '{55, 70, 85};
  localparam int unsigned T_WP_NS     [NUM_GRADES] = '{45, 55, 60};
  localparam int unsigned T_SU_WH_NS  [NUM_GRADES] = '{50, 65, 70};
  localparam int unsigned T_SU_SEL_NS [NUM_GRADES] = '{50, 65, 70};
  localparam int unsigned T_SU_D_NS   [NUM_GRADES] = '{30, 35, 45};
  localparam int unsigned T_DIS_W_NS  [NUM_GRADES] = '{20, 25, 30};

  // ----------------------------------------------------------------
  // Retention timing
  // ----------------------------------------------------------------
  localparam int unsigned T_PD_SU_NS  = 0;
  localparam int unsigned T_PD_REC_MS = 5;
  localparam int unsigned NS_PER_MS   = 1000000;
  localparam int unsigned PD_REC_CYC  = (T_PD_REC_MS * NS_PER_MS) / CLK_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_WR_LOW  = 3'h1,
    ST_WR_REC  = 3'h2,
    ST_PD_HOLD = 3'h3,
    ST_PD_REC  = 3'h4
  } state_t;

  typedef enum logic {
    BYTE_STROBE_RETENTION_MODE = 1'h0,
    SELECT_RETENTION_MODE      = 1'h1
  } pd_mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0]  byte_en;
  } wr_req_t;

  typedef struct packed {
    logic              select_active_low;
    logic              select_active_high;
    logic              lower_byte_strobe_n;
    logic              upper_byte_strobe_n;
    logic              write_strobe_n;
    logic              output_gate_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe_n;
  } sram_pins_t;

  // ----------------------------------------------------------------
  // Cycle counts; least times round up, never below one cycle
  // ----------------------------------------------------------------
  function automatic int unsigned cyc_min(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int unsigned max2(input int unsigned a, input int unsigned b);
    return (a > b) ? a : b;
  endfunction

  // Data stays off the pins until the memory has surely let go
  function automatic int unsigned wr_drv_cyc(input int unsigned g);
    return cyc_min(T_DIS_W_NS[g]);
  endfunction

  function automatic int unsigned wr_low_cyc(input int unsigned g);
    int unsigned a;
    a = cyc_min(T_WP_NS[g]);
    a = max2(a, cyc_min(T_SU_WH_NS[g]));
    a = max2(a, cyc_min(T_SU_SEL_NS[g]));
    a = max2(a, wr_drv_cyc(g) + cyc_min(T_SU_D_NS[g]));
    return a;
  endfunction

  function automatic int unsigned wr_rec_cyc(input int unsigned g);
    return max2(1, max2(cyc_min(T_WC_NS[g]), wr_low_cyc(g) + 1) - wr_low_cyc(g));
  endfunction

endpackage

/* File: core/sram_delay_timer.sv */
`timescale 1ns/1ps
`default_nettype none

// Loaded with N, o_last is high in the N-th cycle after the load edge
module sram_delay_timer #(
  parameter int unsigned TW = 21
) (
  input  wire logic          i_clk,
  input  wire logic          i_rstn,
  input  wire logic          i_load,
  input  wire logic [TW-1:0] i_value,
  output logic      [TW-1:0] o_count,
  output logic               o_last
);

  logic [TW-1:0] cnt_reg;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_reg <= '0;
    end else if (i_load) begin
      cnt_reg <= i_value;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - TW'(1);
    end
  end

  assign o_count = cnt_reg;
  assign o_last  = (cnt_reg == TW'(1));

endmodule

`default_nettype wire

/* File: core/sram_write_retention_host.sv */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// [RQ1] A write happens only while both selects are active, a byte strobe is low and the write strobe is low.
// [RQ2] A write strobe falling no later than the selects and byte strobes keeps the memory outputs off.
// [RQ3] The controller never drives the data pins while the memory may drive them.
// [RQ4] The address is held stable for the address-to-write-end setup time before the write strobe rises.
// [RQ5] Selects and byte strobes stay active for their setup time before the write ends.
// [RQ6] The memory releases its outputs within the disable time after the write strobe falls.
// [RQ7] The memory starts driving no sooner than 5 ns after the write strobe rises.
// [RQ8] The memory releases its outputs within the disable time after the output gate rises.
// [RQ9] The memory starts driving no sooner than 5 ns after the output gate falls.
// [RQ10] The memory is in its deselected retention state before the supply may drop.
// [RQ11] After the supply returns the memory stays deselected for 5 ms before any access.
// [RQ12] In byte strobe retention mode both selects are held at fixed levels during power-down.
// [RQ13] In select retention mode the active-high select is held at a fixed rail during power-down.
// [RQ14] Write cycle time and pulse width are met and data is stable before and at the write end.
// [RQ15] Each byte strobe enables writing of its own byte lane only.
module sram_write_retention_host #(
  parameter int unsigned GRADE             = 0,
  parameter int unsigned PD_REC_CYCLES     = sram_host_pkg::PD_REC_CYC,
  parameter bit          PD_SEL_HIGH_LEVEL = 1'b0,
  parameter int unsigned TW                = 21
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_rstn,
  input  wire logic                    i_wr_valid,
  input  wire sram_host_pkg::wr_req_t  i_wr_req,
  output logic                         o_wr_ready,
  output logic                         o_wr_done,
  input  wire logic                    i_pd_req,
  input  wire sram_host_pkg::pd_mode_t i_pd_mode,
  input  wire logic                    i_supply_ok,
  output logic                         o_pd_safe,
  output sram_host_pkg::sram_pins_t    o_pins
);

  // ----------------------------------------------------------------
  // Timing for the chosen grade
  // ----------------------------------------------------------------
  localparam int unsigned LOW_CYC = sram_host_pkg::wr_low_cyc(GRADE);
  localparam int unsigned REC_CYC = sram_host_pkg::wr_rec_cyc(GRADE);
  localparam int unsigned DRV_CYC = sram_host_pkg::wr_drv_cyc(GRADE);
  localparam int unsigned SU_CYC  = sram_host_pkg::cyc_min(sram_host_pkg::T_SU_SEL_NS[GRADE]);
  localparam int unsigned WP_CYC  = sram_host_pkg::cyc_min(sram_host_pkg::T_WP_NS[GRADE]);
  localparam int unsigned WC_CYC  = sram_host_pkg::cyc_min(sram_host_pkg::T_WC_NS[GRADE]);
  localparam int unsigned DSU_CYC = sram_host_pkg::cyc_min(sram_host_pkg::T_SU_D_NS[GRADE]);

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  sram_host_pkg::state_t   state_reg;
  sram_host_pkg::state_t   state_next;
  sram_host_pkg::pd_mode_t mode_reg;
  logic                    tmr_load;
  logic [TW-1:0]           tmr_value;
  logic [TW-1:0]           tmr_count;
  logic                    tmr_last;
  logic                    wr_take;
  logic                    wr_empty;

  // Power-down wins over a write offered in the same cycle
  assign wr_take  = i_wr_valid && o_wr_ready && !i_pd_req;
  assign wr_empty = (i_wr_req.byte_en == '0);

  sram_delay_timer #(
    .TW (TW)
  ) u_timer (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_load  (tmr_load),
    .i_value (tmr_value),
    .o_count (tmr_count),
    .o_last  (tmr_last)
  );

  always_comb begin
    state_next = state_reg;
    tmr_load   = 1'b0;
    tmr_value  = '0;
    unique case (state_reg)
      sram_host_pkg::ST_IDLE: begin
        if (i_pd_req) begin
          state_next = sram_host_pkg::ST_PD_HOLD; // RQ10
        end else if (wr_take && !wr_empty) begin
          state_next = sram_host_pkg::ST_WR_LOW;
          tmr_load   = 1'b1;
          tmr_value  = TW'(LOW_CYC); // RQ5 RQ14
        end
      end
      sram_host_pkg::ST_WR_LOW: begin
        if (tmr_last) begin
          state_next = sram_host_pkg::ST_WR_REC;
          tmr_load   = 1'b1;
          tmr_value  = TW'(REC_CYC);
        end
      end
      sram_host_pkg::ST_WR_REC: begin
        if (tmr_last) begin
          state_next = sram_host_pkg::ST_IDLE;
        end
      end
      sram_host_pkg::ST_PD_HOLD: begin
        if (!i_pd_req && i_supply_ok) begin
          state_next = sram_host_pkg::ST_PD_REC;
          tmr_load   = 1'b1;
          tmr_value  = TW'(PD_REC_CYCLES); // RQ11
        end
      end
      sram_host_pkg::ST_PD_REC: begin
        // A supply dip or new request restarts the recovery wait
        if (!i_supply_ok || i_pd_req) begin
          state_next = sram_host_pkg::ST_PD_HOLD;
        end else if (tmr_last) begin
          state_next = sram_host_pkg::ST_IDLE; // RQ11
        end
      end
      default: begin
        state_next = sram_host_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= sram_host_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // User handshake
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_wr_ready <= 1'b0;
      o_wr_done  <= 1'b0;
      o_pd_safe  <= 1'b0;
    end else begin
      o_wr_ready <= (state_next == sram_host_pkg::ST_IDLE);
      o_wr_done  <= (state_reg == sram_host_pkg::ST_WR_REC && tmr_last) ||
                    (state_reg == sram_host_pkg::ST_IDLE && wr_take && wr_empty);
      o_pd_safe  <= (state_next == sram_host_pkg::ST_PD_HOLD) ||
                    (state_next == sram_host_pkg::ST_PD_REC); // RQ10
    end
  end

  // ----------------------------------------------------------------
  // Memory pins
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_reg <= sram_host_pkg::BYTE_STROBE_RETENTION_MODE;
    end else if (state_reg == sram_host_pkg::ST_IDLE && i_pd_req) begin
      mode_reg <= i_pd_mode;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pins.select_active_low   <= 1'b1;
      o_pins.select_active_high  <= 1'b0;
      o_pins.lower_byte_strobe_n <= 1'b1;
      o_pins.upper_byte_strobe_n <= 1'b1;
      o_pins.write_strobe_n      <= 1'b1;
      o_pins.output_gate_n       <= 1'b1;
      o_pins.addr                <= '0;
      o_pins.dq_out              <= '0;
      o_pins.dq_oe_n             <= 1'b1;
    end else begin
      // Output gate never falls: this controller only writes
      o_pins.output_gate_n <= 1'b1; // RQ3
      unique case (state_reg)
        sram_host_pkg::ST_IDLE: begin
          if (i_pd_req) begin
            o_pins.lower_byte_strobe_n <= 1'b1;
            o_pins.upper_byte_strobe_n <= 1'b1;
            o_pins.write_strobe_n      <= 1'b1;
            if (i_pd_mode == sram_host_pkg::SELECT_RETENTION_MODE) begin
              o_pins.select_active_low  <= 1'b1; // RQ13
              o_pins.select_active_high <= PD_SEL_HIGH_LEVEL;
            end else begin
              o_pins.select_active_low  <= 1'b0; // RQ12
              o_pins.select_active_high <= 1'b1;
            end
          end else if (wr_take && !wr_empty) begin
            // Selects, write strobe and the enabled byte strobes switch together so the memory never turns on
            o_pins.select_active_low   <= 1'b0; // RQ1
            o_pins.select_active_high  <= 1'b1;
            o_pins.lower_byte_strobe_n <= ~i_wr_req.byte_en[0]; // RQ15
            o_pins.upper_byte_strobe_n <= ~i_wr_req.byte_en[1]; // RQ15
            o_pins.write_strobe_n      <= 1'b0; // RQ2
            o_pins.addr                <= i_wr_req.addr;
            o_pins.dq_out              <= i_wr_req.data;
          end
        end
        sram_host_pkg::ST_WR_LOW: begin
          if (tmr_count == TW'(LOW_CYC - DRV_CYC + 1)) begin
            o_pins.dq_oe_n <= 1'b0; // RQ6
          end
          if (tmr_last) begin
            o_pins.write_strobe_n <= 1'b1; // RQ4
          end
        end
        sram_host_pkg::ST_WR_REC: begin
          // Data and address held past the rising edge for zero hold
          if (tmr_last) begin
            o_pins.select_active_low   <= 1'b1; // RQ14
            o_pins.select_active_high  <= 1'b0;
            o_pins.lower_byte_strobe_n <= 1'b1;
            o_pins.upper_byte_strobe_n <= 1'b1;
            o_pins.dq_oe_n             <= 1'b1;
          end
        end
        sram_host_pkg::ST_PD_REC: begin
          if (state_next == sram_host_pkg::ST_IDLE) begin
            o_pins.select_active_low  <= 1'b1; // RQ11
            o_pins.select_active_high <= 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  int unsigned we_low_cnt;
  int unsigned pd_rec_run;
  // Cycles since the last strobe fall; starts long so the first write passes
  int unsigned wr_gap_cnt;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      we_low_cnt <= 0;
      pd_rec_run <= 0;
      wr_gap_cnt <= WC_CYC;
    end else begin
      we_low_cnt <= o_pins.write_strobe_n ? 0 : we_low_cnt + 1;
      wr_gap_cnt <= (!o_pins.write_strobe_n && we_low_cnt == 0) ? 1 : wr_gap_cnt + 1;
      pd_rec_run <= (state_reg == sram_host_pkg::ST_PD_REC) ? pd_rec_run + 1 : 0;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  sequence wr_start_s;
    $fell(o_pins.write_strobe_n);
  endsequence

  sequence wr_end_s;
    $rose(o_pins.write_strobe_n);
  endsequence

  write_overlap_a: assert property ( // RQ1
    !o_pins.write_strobe_n |-> !o_pins.select_active_low && o_pins.select_active_high &&
    !(o_pins.lower_byte_strobe_n && o_pins.upper_byte_strobe_n))
    else $error("write strobe low without full select and byte strobe");

  no_contention_a: assert property ( // RQ3
    !o_pins.dq_oe_n |-> o_pins.output_gate_n && $past(o_pins.output_gate_n))
    else $error("data driven while memory outputs may be on");

  drive_delay_a: assert property ( // RQ6
    $fell(o_pins.dq_oe_n) |-> !o_pins.write_strobe_n && we_low_cnt == DRV_CYC)
    else $error("data driven before memory outputs released");

  addr_stable_a: assert property ( // RQ4
    !$past(o_pins.write_strobe_n) |-> $stable(o_pins.addr))
    else $error("address moved during write pulse");

  strobe_setup_a: assert property ( // RQ5
    wr_end_s |-> we_low_cnt == LOW_CYC && LOW_CYC >= SU_CYC && LOW_CYC >= WP_CYC &&
    $stable(o_pins.select_active_low) && $stable(o_pins.select_active_high) &&
    $stable(o_pins.lower_byte_strobe_n) && $stable(o_pins.upper_byte_strobe_n))
    else $error("write pulse shorter than select setup");

  data_setup_a: assert property ( // RQ14
    wr_end_s |-> !o_pins.dq_oe_n && !$past(o_pins.dq_oe_n, DSU_CYC) && $stable(o_pins.dq_out))
    else $error("write data not stable at write end");

  cycle_time_a: assert property ( // RQ14
    wr_start_s |-> wr_gap_cnt >= WC_CYC)
    else $error("write cycle cut short");

  retention_fixed_a: assert property ( // RQ12
    o_pd_safe && $past(o_pd_safe) |-> $stable(o_pins.select_active_low) &&
    $stable(o_pins.select_active_high) && o_pins.lower_byte_strobe_n &&
    o_pins.upper_byte_strobe_n && o_pins.write_strobe_n)
    else $error("pins moved during power-down");

  sel_retention_a: assert property ( // RQ13
    o_pd_safe && mode_reg == sram_host_pkg::SELECT_RETENTION_MODE |->
    o_pins.select_active_low && o_pins.select_active_high == PD_SEL_HIGH_LEVEL)
    else $error("active-high select not at its fixed level in power-down");

  pd_entry_a: assert property ( // RQ10
    $rose(o_pd_safe) |-> o_pins.write_strobe_n && (o_pins.select_active_low ||
    !o_pins.select_active_high || (o_pins.lower_byte_strobe_n && o_pins.upper_byte_strobe_n)))
    else $error("safe flag raised before memory deselected");

  pd_recovery_a: assert property ( // RQ11
    $fell(o_pd_safe) |-> pd_rec_run == PD_REC_CYCLES && o_wr_ready)
    else $error("access allowed before recovery time");

endmodule

`default_nettype wire

/* File: verif/sram_memory_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Behavioural memory with pin timing checks
// ----------------------------------------------------------------
module sram_memory_model #(
  parameter int unsigned G      = 0,
  parameter realtime     REC_NS = 100.0
) (
  input  wire sram_host_pkg::sram_pins_t i_pins,
  input  wire logic [15:0]               i_dq,
  input  wire logic                      i_supply_low,
  input  wire logic [18:0]               i_peek_addr,
  output logic      [15:0]               o_peek_data,
  output logic      [15:0]               o_dq,
  output logic                           o_drv,
  output int                             o_viol
);
  logic [15:0] mem [logic [18:0]];
  logic [1:0]  sb_q = 2'h0;
  logic [1:0]  on_q = 2'h0;
  logic [1:0]  ss_q;
  logic [18:0] a_q;
  logic [15:0] d_q;
  logic        we_q = 1'b1;
  logic        low_q = 1'b0;
  realtime     t_a, t_d, t_w, now;
  realtime     t_wc = -1.0e6;
  realtime     t_up = -1.0e9;
  realtime     t_s [2];
  int          viol = 0;
  int          wr_cnt = 0;
  wire         sel = !i_pins.select_active_low && i_pins.select_active_high;
  wire   [1:0] sb = {2{sel}} & ~{i_pins.upper_byte_strobe_n, i_pins.lower_byte_strobe_n};
  wire   [1:0] on = sb & {2{!i_pins.write_strobe_n}};
  // No lane selected is standby in either retention mode
  wire         ret = (sb == 2'h0);

  function automatic logic [15:0] rd(input logic [18:0] a);
    return mem.exists(a) ? mem[a] : 16'h0000;
  endfunction

  assign o_viol = viol;
  // Drive only after the enable time, let go at once
  assign #(5, 0) o_drv = !i_pins.output_gate_n && i_pins.write_strobe_n && ret == 1'b0;

  always @(i_peek_addr or i_pins.addr or wr_cnt) begin
    o_peek_data = rd(i_peek_addr);
    o_dq = rd(i_pins.addr);
  end

  // One process, so old values are used when pins change together
  always @(i_pins or i_dq or i_supply_low) begin
    now = $realtime;
    for (int i = 0; i < 2; i++) begin
      if (on_q[i] && !on[i]) begin
        mem[a_q] = rd(a_q);
        mem[a_q][8*i +: 8] = d_q[8*i +: 8];
        if (now - t_a < sram_host_pkg::T_SU_WH_NS[G]) viol++;
        if (now - t_s[i] < sram_host_pkg::T_SU_SEL_NS[G]) viol++;
        if (now - t_w < sram_host_pkg::T_WP_NS[G]) viol++;
        if (now - t_d < sram_host_pkg::T_SU_D_NS[G]) viol++;
        wr_cnt++;
      end
      if (!sb_q[i] && sb[i]) t_s[i] = now;
    end
    if (we_q && !i_pins.write_strobe_n) begin
      if (now - t_wc < sram_host_pkg::T_WC_NS[G]) viol++;
      t_w = now;
      t_wc = now;
    end
    if (i_pins.addr !== a_q) begin
      a_q = i_pins.addr;
      t_a = now;
    end
    if (i_dq !== d_q) begin
      d_q = i_dq;
      t_d = now;
    end
    if (o_drv && !i_pins.dq_oe_n) viol++;
    if (i_supply_low && !low_q) ss_q = {i_pins.select_active_low, i_pins.select_active_high};
    if (i_supply_low && (!ret || ss_q !== {i_pins.select_active_low, i_pins.select_active_high}))
      viol++;
    if (!i_supply_low && low_q) t_up = now;
    if (!ret && now - t_up < REC_NS) viol++;
    low_q = i_supply_low;
    sb_q = sb;
    on_q = on;
    we_q = i_pins.write_strobe_n;
  end
endmodule

`default_nettype wire

/* File: verif/async_sram_write_and_retention_test.sv */
`timescale 1ns/1ps
`default_nettype none

module async_sram_write_and_retention_test;
  localparam int unsigned G      = 0;
  localparam int unsigned REC    = 20;
  localparam bit          SEL_HI = 1'b0;
  logic                      i_clk = 1'b0;
  logic                      i_rstn = 1'b0;
  logic                      wr_valid = 1'b0;
  sram_host_pkg::wr_req_t    wr_req = '0;
  logic                      pd_req = 1'b0;
  sram_host_pkg::pd_mode_t   pd_mode = sram_host_pkg::BYTE_STROBE_RETENTION_MODE;
  logic                      supply_ok = 1'b1;
  logic                      supply_low = 1'b0;
  logic [18:0]               peek_addr = 19'h0_0000;
  logic                      o_wr_ready, o_wr_done, o_pd_safe, drv;
  sram_host_pkg::sram_pins_t pins;
  logic [15:0]               peek_data, mem_dq;
  logic [15:0]               dq_hold = 16'h0000;
  int                        viol;
  int                        n_mismatch = 0;
  int                        tests_run = 0;
  logic [15:0]               exp_mem [logic [18:0]];
  wire  [15:0]               dq_w = !pins.dq_oe_n ? pins.dq_out : (drv ? mem_dq : ~dq_hold);

  always #2.5 i_clk = ~i_clk;
  // A released bus shows a changing pattern, never a stale word
  always @(posedge i_clk) dq_hold <= dq_w;

  sram_write_retention_host #(
    .GRADE             (G),
    .PD_REC_CYCLES     (REC),
    .PD_SEL_HIGH_LEVEL (SEL_HI),
    .TW                (21)
  ) dut (
    .i_clk       (i_clk),
    .i_rstn      (i_rstn),
    .i_wr_valid  (wr_valid),
    .i_wr_req    (wr_req),
    .o_wr_ready  (o_wr_ready),
    .o_wr_done   (o_wr_done),
    .i_pd_req    (pd_req),
    .i_pd_mode   (pd_mode),
    .i_supply_ok (supply_ok),
    .o_pd_safe   (o_pd_safe),
    .o_pins      (pins)
  );

  sram_memory_model #(.G(G), .REC_NS(REC * 5.0)) mem_i (
    .i_pins       (pins),
    .i_dq         (dq_w),
    .i_supply_low (supply_low),
    .i_peek_addr  (peek_addr),
    .o_peek_data  (peek_data),
    .o_dq         (mem_dq),
    .o_drv        (drv),
    .o_viol       (viol)
  );

  // ----------------------------------------------------------------
  // Expectations and checks
  // ----------------------------------------------------------------
  function automatic int cyc(input int unsigned ns);
    return (ns + sram_host_pkg::CLK_NS - 1) / sram_host_pkg::CLK_NS;
  endfunction

  // Strobe low covers every setup; recovery tops up the cycle time
  function automatic int exp_lat(input logic [1:0] be);
    int lo;
    lo = cyc(sram_host_pkg::T_DIS_W_NS[G]) + cyc(sram_host_pkg::T_SU_D_NS[G]);
    if (cyc(sram_host_pkg::T_WP_NS[G]) > lo) lo = cyc(sram_host_pkg::T_WP_NS[G]);
    if (cyc(sram_host_pkg::T_SU_WH_NS[G]) > lo) lo = cyc(sram_host_pkg::T_SU_WH_NS[G]);
    if (cyc(sram_host_pkg::T_SU_SEL_NS[G]) > lo) lo = cyc(sram_host_pkg::T_SU_SEL_NS[G]);
    if (cyc(sram_host_pkg::T_WC_NS[G]) > lo + 1) lo = cyc(sram_host_pkg::T_WC_NS[G]) - 1;
    return (be == 2'h0) ? 0 : lo + 1;
  endfunction

  function automatic logic [15:0] exp_of(input logic [18:0] a);
    return exp_mem.exists(a) ? exp_mem[a] : 16'h0000;
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] w, d, input logic [1:0] be);
    if (be[0]) w[7:0] = d[7:0];
    if (be[1]) w[15:8] = d[15:8];
    return w;
  endfunction

  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic results();
    if (n_mismatch == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic give_up();
    check(1'b0, "wait timed out");
    results();
  endtask

  task automatic do_write(input logic [18:0] a, input logic [15:0] d, input logic [1:0] be);
    int k;
    wr_valid <= 1'b1;
    wr_req <= '{addr: a, data: d, byte_en: be};
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_wr_ready !== 1'b1 && k < 40);
    wr_valid <= 1'b0;
    if (k >= 40) give_up();
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
      if (k > 1 && o_wr_ready === 1'b1 && o_wr_done !== 1'b1) check(1'b0, "ready while busy");
    end while (o_wr_done !== 1'b1 && k < 40);
    if (k >= 40) give_up();
    check(k == exp_lat(be) + 1, "write latency");
    exp_mem[a] = merge(exp_of(a), d, be);
  endtask

  task automatic peek(input logic [18:0] a);
    peek_addr <= a;
    repeat (2) @(posedge i_clk);
    check(peek_data === exp_of(a), "stored word");
  endtask

  task automatic pd_cycle(input sram_host_pkg::pd_mode_t m);
    int k;
    pd_mode <= m;
    pd_req <= 1'b1;
    wr_valid <= 1'b1;
    wr_req <= '{addr: 19'h0_0005, data: 16'h5A5A, byte_en: 2'h3};
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_pd_safe !== 1'b1 && k < 4);
    if (k >= 4) give_up();
    if (m == sram_host_pkg::BYTE_STROBE_RETENTION_MODE)
      check({pins.lower_byte_strobe_n, pins.upper_byte_strobe_n} === 2'h3, "byte mode");
    else
      check({pins.select_active_low, pins.select_active_high} === {1'b1, SEL_HI}, "sel mode");
    supply_low <= 1'b1;
    supply_ok <= 1'b0;
    repeat (10) @(posedge i_clk);
    check(o_wr_ready === 1'b0 && o_pd_safe === 1'b1, "held in retention");
    supply_low <= 1'b0;
    supply_ok <= 1'b1;
    pd_req <= 1'b0;
    wr_valid <= 1'b0;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_wr_ready !== 1'b1 && k < 60);
    if (k >= 60) give_up();
    check(k > REC && k <= REC + 4, "recovery length");
    peek(19'h0_0005);
  endtask

  initial begin
    void'($urandom(38810));
    repeat (12) @(posedge i_clk);
    check(pins.write_strobe_n === 1'b1 && pins.select_active_low === 1'b1
          && pins.dq_oe_n === 1'b1, "reset pins");
    i_rstn <= 1'b1;
    repeat (2) @(posedge i_clk);
    do_write(19'h7_FFFF, 16'hA5C3, 2'h3);
    do_write(19'h7_FFFF, 16'h1234, 2'h2);
    do_write(19'h7_FFFF, 16'h5678, 2'h1);
    do_write(19'h7_FFFF, 16'hFFFF, 2'h0);
    peek(19'h7_FFFF);
    for (int i = 0; i < 40; i++)
      do_write(19'($urandom_range(0, 7)), 16'($urandom), 2'($urandom_range(0, 3)));
    for (int i = 0; i < 8; i++)
      peek(19'(i));
    pd_cycle(sram_host_pkg::BYTE_STROBE_RETENTION_MODE);
    pd_cycle(sram_host_pkg::SELECT_RETENTION_MODE);
    do_write(19'h0_0005, 16'hC0DE, 2'h3);
    peek(19'h0_0005);
    check(viol === 0, "pin timing at memory");
    results();
  end
endmodule

`default_nettype wire
